// ---- core/cidx_exec.sv ----
// execution of call, complement, clear, decrement and skip operations
// assumes the register file answers a read address in the same cycle,
// and that the return stack and pc take the call strobes when they pulse
`timescale 1ns/100ps
`include "cidx_consts.svh"

// Contract
// - a call pushes the address of the next instruction, pc plus one, onto the return stack.
// - a call loads its 11-bit target into pc bits 10 down to 0.
// - a call fills pc bits 12:11 from bits 4:3 of the upper program-counter latch.
// - a call takes two cycles and leaves every status flag alone.
// - complement inverts the register, writes acc (d=0) or register (d=1), updates zero.
// - register clear writes zero to the register and sets the zero flag.
// - accumulator clear writes zero to the accumulator and sets the zero flag.
// - decrement subtracts one and writes accumulator or register by d, updating zero.
// - decrement-and-skip subtracts one and writes by d without touching any flag.
// - a zero decrement-and-skip result replaces the next instruction with an idle slot.
// - increment-and-skip adds one and writes by d without touching any flag.
// - a zero increment-and-skip result replaces the next instruction with an idle slot.
module cidx_exec
  import cidx_pkg::*;
#(
  // lengths of the two-cycle operations
  parameter int CALL_CYCLES = `CIDX_CALL_CYCLES,
  parameter int SKIP_CYCLES = `CIDX_SKIP_CYCLES
)
(
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // instruction issue from fetch
  input wire logic insn_valid,
  input wire cidx_pkg::cidx_issue_t issue,
  output logic insn_ready,
  // register file read
  output logic [`CIDX_FADDR_W-1:0] reg_raddr,
  input wire logic [`CIDX_DATA_W-1:0] reg_rdata,
  // register file write-back
  output cidx_pkg::cidx_wb_t reg_wb,
  // upper program-counter latch
  input wire logic [`CIDX_DATA_W-1:0] upper_program_counter_latch,
  // return stack and pc
  output cidx_pkg::cidx_call_t call_out,
  // accumulator and zero flag
  output logic [`CIDX_DATA_W-1:0] acc,
  output logic zero_flag,
  // pipeline status
  output logic idle_slot_op,
  output logic insn_unknown
);

  // decode and handshake
  cidx_op_t op;
  logic fire;
  logic dest_reg;
  logic is_call;
  logic is_exec;

  // alu results
  logic [`CIDX_DATA_W-1:0] alu_result;
  logic alu_wr_reg;
  logic alu_wr_acc;
  logic alu_zero_upd;
  logic alu_zero_val;
  logic alu_skip;

  // sequencer
  cidx_state_t state_r;
  cidx_state_t state_nxt;

  // idle slots still to run after a two-cycle operation
  localparam int SLOT_W = $clog2(CALL_CYCLES + SKIP_CYCLES) + 1;
  logic [SLOT_W-1:0] slots_r;
  logic [SLOT_W-1:0] slots_nxt;

  // architectural state
  logic [`CIDX_DATA_W-1:0] acc_r;
  logic [`CIDX_DATA_W-1:0] acc_nxt;
  logic zero_r;
  logic zero_nxt;

  // write-back and status outputs
  cidx_wb_t wb_r;
  cidx_wb_t wb_nxt;
  logic unknown_r;
  logic unknown_nxt;

  // decode of the offered instruction
  assign op = cidx_decode(issue.insn);
  assign dest_reg = issue.insn[`CIDX_DEST_BIT];
  assign is_call = (op == OP_CALL);
  assign is_exec = (op != OP_NONE) && !is_call;

  // ready only in the execute state and while enabled
  assign insn_ready = clk_en && (state_r == ST_EXEC);
  assign fire = insn_valid && insn_ready;

  // operand address, seven bits of the current bank
  assign reg_raddr = issue.insn[`CIDX_FADDR_HI:0];

  // register operation datapath
  cidx_alu cidx_alu_i (
    .op(op),
    .dest_reg(dest_reg),
    .operand(reg_rdata),
    .result(alu_result),
    .wr_reg(alu_wr_reg),
    .wr_acc(alu_wr_acc),
    .zero_upd(alu_zero_upd),
    .zero_val(alu_zero_val),
    .skip(alu_skip)
  );

  // call strobes toward stack and pc
  cidx_call_unit cidx_call_unit_i (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .fire(fire && is_call),
    .pc(issue.pc),
    .target_low(issue.insn[`CIDX_TGT_W-1:0]),
    .latch_upper(upper_program_counter_latch),
    .call_out(call_out)
  );

  // sequencer: a call or a taken skip costs one idle slot
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_EXEC: begin
        if (fire && is_call) begin
          state_nxt = ST_IDLE_SLOT;
        end else if (fire && alu_skip) begin
          state_nxt = ST_IDLE_SLOT;
        end else begin
          state_nxt = ST_EXEC;
        end
      end
      ST_IDLE_SLOT: begin
        if (slots_r <= SLOT_W'(1)) begin
          state_nxt = ST_EXEC;
        end
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_EXEC;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // idle-slot counter, loaded with the extra cycles of a call or taken skip
  always_comb begin
    slots_nxt = slots_r;
    if (fire && is_call) begin
      slots_nxt = SLOT_W'(CALL_CYCLES - 1);
    end else if (fire && alu_skip) begin
      slots_nxt = SLOT_W'(SKIP_CYCLES - 1);
    end else if (slots_r != '0) begin
      slots_nxt = slots_r - SLOT_W'(1);
    end
  end

  // idle-slot counter register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slots_r <= '0;
    end else if (clk_en) begin
      slots_r <= slots_nxt;
    end
  end

  // accumulator and zero flag next values
  always_comb begin
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    if (fire && is_exec) begin
      if (alu_wr_acc) begin
        acc_nxt = alu_result;
      end
      if (alu_zero_upd) begin
        zero_nxt = alu_zero_val;
      end
    end
    // calls and skip forms leave zero untouched
  end

  // accumulator and zero flag registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= `CIDX_ACC_RST;
      zero_r <= `CIDX_ZERO_RST;
    end else if (clk_en) begin
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // register write-back, one pulse per written result
  always_comb begin
    wb_nxt = '0;
    unknown_nxt = 1'b0;
    if (fire) begin
      if (is_exec && alu_wr_reg) begin
        wb_nxt.valid = 1'b1;
        wb_nxt.addr = issue.insn[`CIDX_FADDR_HI:0];
        wb_nxt.data = alu_result;
      end
      unknown_nxt = (op == OP_NONE);
    end
  end

  // write-back and status registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_r <= '0;
      unknown_r <= 1'b0;
    end else if (clk_en) begin
      wb_r <= wb_nxt;
      unknown_r <= unknown_nxt;
    end
  end

  // outputs
  assign reg_wb = wb_r;
  assign acc = acc_r;
  assign zero_flag = zero_r;
  assign insn_unknown = unknown_r;

  // idle slot marks the discarded instruction or the second call cycle
  assign idle_slot_op = (state_r == ST_IDLE_SLOT);

endmodule

// ---- core/cidx_consts.svh ----
// constants for the call / increment / decrement execution block
// assumes 14-bit instruction words and a 13-bit program counter
`ifndef CIDX_CONSTS_SVH
`define CIDX_CONSTS_SVH

// widths
`define CIDX_INSN_W 14
`define CIDX_PC_W 13
`define CIDX_TGT_W 11
`define CIDX_FADDR_W 7
`define CIDX_DATA_W 8

// upper program-counter latch bits copied into pc 12:11
`define CIDX_LATCH_HI 4
`define CIDX_LATCH_LO 3

// instruction field positions
`define CIDX_CALL_HI 13
`define CIDX_CALL_LO 11
`define CIDX_GRP_HI 13
`define CIDX_GRP_LO 8
`define CIDX_DEST_BIT 7
`define CIDX_FADDR_HI 6

// opcode patterns
`define CIDX_OPC_CALL 3'h4
`define CIDX_OPC_INVERT 6'h09
`define CIDX_OPC_ZERO 6'h01
`define CIDX_OPC_SUB 6'h03
`define CIDX_OPC_SUB_SKIP 6'h0B
`define CIDX_OPC_ADD_SKIP 6'h0F

// reset values
`define CIDX_ACC_RST 8'h00
`define CIDX_ZERO_RST 1'b0
`define CIDX_PC_RST 13'h0000

// cycle counts of long operations
`define CIDX_CALL_CYCLES 2
`define CIDX_SKIP_CYCLES 2

`endif

// ---- core/cidx_pkg.sv ----
// types shared by the call / increment / decrement execution block
// assumes the constants header is on the include path
`include "cidx_consts.svh"

package cidx_pkg;

  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE,
    OP_CALL,
    OP_INVERT,
    OP_ZERO_REG,
    OP_ZERO_ACC,
    OP_SUB,
    OP_SUB_SKIP,
    OP_ADD_SKIP
  } cidx_op_t;

  // sequencer state
  typedef enum logic {
    ST_EXEC,
    ST_IDLE_SLOT
  } cidx_state_t;

  // instruction handed over by the fetch pipeline
  typedef struct packed {
    logic [`CIDX_INSN_W-1:0] insn;
    logic [`CIDX_PC_W-1:0] pc;
  } cidx_issue_t;

  // register file write-back
  typedef struct packed {
    logic valid;
    logic [`CIDX_FADDR_W-1:0] addr;
    logic [`CIDX_DATA_W-1:0] data;
  } cidx_wb_t;

  // return stack push and program counter load
  typedef struct packed {
    logic push;
    logic [`CIDX_PC_W-1:0] ret_addr;
    logic load;
    logic [`CIDX_PC_W-1:0] target;
  } cidx_call_t;

  // instruction decode, used for issue and for operand selection
  function automatic cidx_op_t cidx_decode(input logic [`CIDX_INSN_W-1:0] insn);
    cidx_op_t op;
    op = OP_NONE;
    if (insn[`CIDX_CALL_HI:`CIDX_CALL_LO] == `CIDX_OPC_CALL) begin
      op = OP_CALL;
    end else begin
      unique case (insn[`CIDX_GRP_HI:`CIDX_GRP_LO])
        `CIDX_OPC_INVERT: op = OP_INVERT;
        `CIDX_OPC_ZERO: op = insn[`CIDX_DEST_BIT] ? OP_ZERO_REG : OP_ZERO_ACC;
        `CIDX_OPC_SUB: op = OP_SUB;
        `CIDX_OPC_SUB_SKIP: op = OP_SUB_SKIP;
        `CIDX_OPC_ADD_SKIP: op = OP_ADD_SKIP;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction

endpackage

// ---- core/cidx_alu.sv ----
// result, zero flag and skip decision for the register operations
// purely combinational; operand comes straight from the register file
`timescale 1ns/100ps
`include "cidx_consts.svh"

module cidx_alu
  import cidx_pkg::*;
(
  // operation
  input wire cidx_pkg::cidx_op_t op,
  input wire logic dest_reg,
  input wire logic [`CIDX_DATA_W-1:0] operand,
  // results
  output logic [`CIDX_DATA_W-1:0] result,
  output logic wr_reg,
  output logic wr_acc,
  output logic zero_upd,
  output logic zero_val,
  output logic skip
);

  logic res_zero;

  // per-operation result and destination, then zero detect on the result
  always_comb begin
    result = operand;
    wr_reg = 1'b0;
    wr_acc = 1'b0;
    zero_upd = 1'b0;
    zero_val = 1'b0;
    skip = 1'b0;
    unique case (op)
      OP_INVERT: begin
        result = ~operand;
        wr_reg = dest_reg;
        wr_acc = ~dest_reg;
        zero_upd = 1'b1;
      end
      OP_ZERO_REG: begin
        result = `CIDX_DATA_W'(0);
        wr_reg = 1'b1;
        zero_upd = 1'b1;
        zero_val = 1'b1;
      end
      OP_ZERO_ACC: begin
        result = `CIDX_DATA_W'(0);
        wr_acc = 1'b1;
        zero_upd = 1'b1;
        zero_val = 1'b1;
      end
      OP_SUB: begin
        result = operand - `CIDX_DATA_W'(1);
        wr_reg = dest_reg;
        wr_acc = ~dest_reg;
        zero_upd = 1'b1;
      end
      OP_SUB_SKIP: begin
        result = operand - `CIDX_DATA_W'(1);
        wr_reg = dest_reg;
        wr_acc = ~dest_reg;
        skip = 1'b1;
      end
      OP_ADD_SKIP: begin
        result = operand + `CIDX_DATA_W'(1);
        wr_reg = dest_reg;
        wr_acc = ~dest_reg;
        skip = 1'b1;
      end
      default: begin
        result = operand;
      end
    endcase
    // eight-bit zero detect; a skip only stands for a zero result
    res_zero = (result == `CIDX_DATA_W'(0));
    zero_val = zero_val || res_zero;
    skip = skip && res_zero;
  end

endmodule

// ---- core/cidx_call_unit.sv ----
// subroutine call: return address push and program counter load
// assumes the caller pulses fire for one accepted call instruction
`timescale 1ns/100ps
`include "cidx_consts.svh"

module cidx_call_unit
  import cidx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // accepted call
  input wire logic fire,
  input wire logic [`CIDX_PC_W-1:0] pc,
  input wire logic [`CIDX_TGT_W-1:0] target_low,
  input wire logic [`CIDX_DATA_W-1:0] latch_upper,
  // stack and pc strobes
  output cidx_pkg::cidx_call_t call_out
);

  cidx_call_t call_r;
  cidx_call_t call_nxt;

  // one-cycle push of pc+1 together with the new pc
  always_comb begin
    call_nxt = '0;
    if (fire) begin
      call_nxt.push = 1'b1;
      call_nxt.ret_addr = `CIDX_PC_W'(pc + `CIDX_PC_W'(1));
      call_nxt.load = 1'b1;
      call_nxt.target = {latch_upper[`CIDX_LATCH_HI:`CIDX_LATCH_LO],
                         target_low};
    end
  end

  // register strobes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      call_r <= '0;
    end else if (clk_en) begin
      call_r <= call_nxt;
    end
  end

  assign call_out = call_r;

endmodule

// ---- sim/cidx_exec_assertions.sv ----
// port checker for the call / increment / decrement execution block
// assumes clk_en stays high across each checked operation
`timescale 1ns/100ps

module cidx_exec_assertions
  import cidx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // issue
  input wire logic insn_valid,
  input wire cidx_pkg::cidx_issue_t issue,
  input wire logic insn_ready,
  // register file
  input wire logic [6:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  input wire cidx_pkg::cidx_wb_t reg_wb,
  // call and status
  input wire logic [7:0] upper_program_counter_latch,
  input wire cidx_pkg::cidx_call_t call_out,
  input wire logic [7:0] acc,
  input wire logic zero_flag,
  input wire logic idle_slot_op,
  input wire logic insn_unknown
);
  // decoded view of the accepted word
  logic fire, is_call, is_skip, zero_skip, dest;
  logic [5:0] grp;
  logic [12:0] tgt;
  assign fire = insn_valid && insn_ready;
  assign grp = issue.insn[13:8];
  assign dest = issue.insn[7];
  assign tgt = {upper_program_counter_latch[4:3], issue.insn[10:0]};
  assign is_call = fire && issue.insn[13:11] == 3'h4;
  assign is_skip = fire && (grp == 6'h0B || grp == 6'h0F);
  assign zero_skip = is_skip && reg_rdata == (grp == 6'h0B ? 8'h01 : 8'hFF);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // one idle slot, then acceptance again
  sequence s_idle_once;
    idle_slot_op && !insn_ready ##1 !idle_slot_op;
  endsequence

  a_call_ret_addr: assert property (
    is_call |=> call_out.push && call_out.ret_addr == $past(issue.pc) + 13'h0001)
    else $error("call return address wrong");
  a_call_target: assert property (
    is_call |=> call_out.load && call_out.target == $past(tgt))
    else $error("call target wrong");
  a_call_two_cycles: assert property (is_call |=> s_idle_once)
    else $error("call length wrong");
  a_call_flags: assert property (is_call |=> $stable(zero_flag))
    else $error("call changed zero flag");
  a_skip_flags: assert property (is_skip |=> $stable(zero_flag))
    else $error("skip changed zero flag");
  a_skip_idle: assert property (zero_skip |=> s_idle_once)
    else $error("zero skip gave no idle slot");
  a_single_cycle: assert property (
    fire && !is_call && !zero_skip |=> !idle_slot_op)
    else $error("one-cycle operation stalled");
  a_clear_zero: assert property (
    fire && grp == 6'h01 |=> zero_flag &&
    ($past(dest) ? reg_wb.valid && reg_wb.data == 8'h00 : acc == 8'h00))
    else $error("clear result wrong");
  a_invert_wb: assert property (
    fire && grp == 6'h09 && dest |=> reg_wb.valid && reg_wb.data == ~$past(reg_rdata)
    && zero_flag == (reg_wb.data == 8'h00))
    else $error("complement result wrong");
  a_dec_acc: assert property (
    fire && grp == 6'h03 && !dest |=> acc == $past(reg_rdata) - 8'h01 && !reg_wb.valid)
    else $error("decrement result wrong");
  a_wb_addr: assert property (
    fire && dest && grp inside {6'h01, 6'h03, 6'h09, 6'h0B, 6'h0F} |=>
    reg_wb.valid && reg_wb.addr == $past(issue.insn[6:0]))
    else $error("write-back address wrong");
  a_operand_addr: assert property (reg_raddr == issue.insn[6:0])
    else $error("operand address wrong");
endmodule

bind cidx_exec cidx_exec_assertions cidx_exec_assertions_i (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .insn_valid(insn_valid),
  .issue(issue), .insn_ready(insn_ready), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
  .reg_wb(reg_wb), .upper_program_counter_latch(upper_program_counter_latch),
  .call_out(call_out), .acc(acc), .zero_flag(zero_flag), .idle_slot_op(idle_slot_op),
  .insn_unknown(insn_unknown));

// ---- sim/call_and_inc_dec_exec_test.sv ----
// self-checking bench for the execution block, operand driven by hand
// assumes the checker file binds itself to the design
`timescale 1ns/100ps

module call_and_inc_dec_exec_test;
  import cidx_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, insn_valid = 1'b0, z = 1'b0;
  cidx_issue_t issue = '0;
  logic [7:0] reg_rdata = 8'h00, upper_program_counter_latch = 8'h00, acc;
  logic insn_ready, idle_slot_op, insn_unknown, zero_flag;
  logic [6:0] reg_raddr;
  cidx_wb_t reg_wb;
  cidx_call_t call_out;
  int mismatches = 0, cmp_count = 0, cycles = 0;

  always #4 sys_clk = ~sys_clk;

  cidx_exec cidx_exec_i (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .insn_valid(insn_valid),
    .issue(issue), .insn_ready(insn_ready), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .reg_wb(reg_wb), .upper_program_counter_latch(upper_program_counter_latch),
    .call_out(call_out), .acc(acc), .zero_flag(zero_flag), .idle_slot_op(idle_slot_op),
    .insn_unknown(insn_unknown));

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // offer one word once ready, leave its answer cycle showing
  task automatic op(input logic [13:0] i, input logic [12:0] p, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (insn_ready !== 1'b1 && n < 8) begin
      n++;
      @(negedge sys_clk);
    end
    check(insn_ready, 1'b1);
    z = zero_flag;
    insn_valid = 1'b1;
    issue = '{insn: i, pc: p};
    reg_rdata = d;
    @(negedge sys_clk);
    insn_valid = 1'b0;
    reg_rdata = ~d;
  endtask

  task automatic t_call(input logic [10:0] k, input logic [12:0] p, input logic [7:0] l,
      input logic [12:0] tgt);
    upper_program_counter_latch = l;
    op({3'h4, k}, p, 8'h00);
    check({call_out.push, call_out.load}, 2'h3);
    check(call_out.ret_addr, p + 13'h0001);
    check(call_out.target, tgt);
    check({idle_slot_op, insn_ready}, 2'h2);
    check(zero_flag, z);
    @(negedge sys_clk);
    check({insn_ready, call_out.push, call_out.load}, 3'h4);
  endtask

  // register operation with its result, zero update and skip expectation
  task automatic t_reg(input logic [13:0] i, input logic [7:0] d, input logic [7:0] r,
      input logic zu, input logic sk);
    op(i, 13'h0040, d);
    check(reg_wb.valid, i[7]);
    check(reg_raddr, i[6:0]);
    if (i[7]) begin
      check(reg_wb.addr, i[6:0]);
      check(reg_wb.data, r);
    end else begin
      check(acc, r);
    end
    check(zero_flag, zu ? (r == 8'h00) : z);
    check(idle_slot_op, sk);
    check(insn_ready, !sk);
  endtask

  task automatic t_invert();
    t_reg(14'h09A0, 8'h0F, 8'hF0, 1'b1, 1'b0);
    t_reg(14'h0905, 8'hFF, 8'h00, 1'b1, 1'b0);
  endtask

  task automatic t_clear();
    t_reg(14'h0905, 8'h00, 8'hFF, 1'b1, 1'b0);
    t_reg(14'h0100, 8'h5A, 8'h00, 1'b1, 1'b0);
    t_reg(14'h0905, 8'h00, 8'hFF, 1'b1, 1'b0);
    t_reg(14'h01FF, 8'hA5, 8'h00, 1'b1, 1'b0);
  endtask

  task automatic t_dec();
    t_reg(14'h03A1, 8'h01, 8'h00, 1'b1, 1'b0);
    t_reg(14'h0311, 8'h00, 8'hFF, 1'b1, 1'b0);
  endtask

  // zero results first with the flag low, non-zero ones with it high
  task automatic t_skip();
    t_reg(14'h0B90, 8'h01, 8'h00, 1'b0, 1'b1);
    t_reg(14'h0F0F, 8'hFF, 8'h00, 1'b0, 1'b1);
    t_reg(14'h0100, 8'h00, 8'h00, 1'b1, 1'b0);
    t_reg(14'h0B92, 8'h05, 8'h04, 1'b0, 1'b0);
    t_reg(14'h0F33, 8'h10, 8'h11, 1'b0, 1'b0);
  endtask

  // reset in mid-run, while the last answer still shows
  task automatic t_reset();
    resetn = 1'b0;
    @(negedge sys_clk);
    check({acc, zero_flag, idle_slot_op, insn_unknown, reg_wb.valid, call_out.push}, 13'h0000);
    check(insn_ready, clk_en);
    resetn = 1'b1;
  endtask

  // clock enable low holds every register, a standing pulse included
  task automatic t_freeze();
    op(14'h01A5, 13'h0050, 8'h77);
    clk_en = 1'b0;
    @(negedge sys_clk);
    check({reg_wb.valid, reg_wb.addr, reg_wb.data}, {1'b1, 7'h25, 8'h00});
    check(zero_flag, 1'b1);
    check(insn_ready, 1'b0);
    clk_en = 1'b1;
    @(negedge sys_clk);
    check(reg_wb.valid, 1'b0);
  endtask

  task automatic t_unknown();
    op(14'h0000, 13'h0041, 8'h00);
    check({insn_unknown, reg_wb.valid}, 2'h2);
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    check({acc, zero_flag, idle_slot_op}, 10'h000);
    t_call(11'h123, 13'h0100, 8'h18, 13'h1923);
    t_call(11'h7FF, 13'h1FFE, 8'hE7, 13'h07FF);
    t_invert();
    t_clear();
    t_dec();
    t_skip();
    t_reset();
    t_freeze();
    t_unknown();
    conclude();
  end
endmodule
